// File: src/tmp_pkg.sv
// package for the triple-modulus prescaler: counts, modes, state layout
// assumes one design clock; the divided input is sampled on it
package tmp_pkg;

  // prescaler terminal counts (divide by 4 or 5)
  localparam logic [2:0] PRE_TOP_DIV4  = 3'h3;
  localparam logic [2:0] PRE_TOP_DIV5  = 3'h4;
  localparam logic [2:0] PRE_FIRST     = 3'h0;
  // counter terminal counts (16 or 18 prescaler periods)
  localparam logic [4:0] CNT_LAST_16   = 5'h0f;
  localparam logic [4:0] CNT_LAST_18   = 5'h11;
  localparam logic [4:0] CNT_FIRST     = 5'h00;
  // input count 32 is counter 8, prescaler 0
  localparam logic [4:0] CNT_RISE      = 5'h08;
  // whole-cycle moduli, as last input count of a cycle
  localparam logic [6:0] LAST_POS_64   = 7'h3f;
  localparam logic [6:0] LAST_POS_65   = 7'h40;
  localparam logic [6:0] LAST_POS_72   = 7'h47;

  // output edge delay after the input edge
  localparam int OUTPUT_EDGE_DELAY_NS  = 10;
  localparam int REF_CLK_PERIOD_NS     = 8;
  localparam int OUTPUT_EDGE_DELAY_CYC =
    (OUTPUT_EDGE_DELAY_NS / REF_CLK_PERIOD_NS) < 1 ? 1 :
    (OUTPUT_EDGE_DELAY_NS / REF_CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    MODE_DIV64,
    MODE_DIV65,
    MODE_DIV72
  } tmp_mode_type;

  typedef struct packed {
    logic         in_prev;
    logic [2:0]   pre;
    logic [4:0]   cnt;
    logic         out;
    tmp_mode_type mode;
  } tmp_state_type;

  // modulus selects to mode
  function automatic tmp_mode_type mode_of(input logic sel_a,
                                           input logic sel_b);
    if (sel_b) begin
      return MODE_DIV72;
    end else if (sel_a) begin
      return MODE_DIV64;
    end else begin
      return MODE_DIV65;
    end
  endfunction

  function automatic logic [4:0] cnt_last(input tmp_mode_type m);
    return (m == MODE_DIV72) ? CNT_LAST_18 : CNT_LAST_16;
  endfunction

endpackage

// File: src/tmp_prescaler.sv
// triple-modulus prescaler: divides a sampled input by 64, 65 or 72
// assumes hf_in is synchronous to ref_clk and below half its rate
//
// Operation
// - a divide-by-4/5 prescaler feeds a five-stage synchronous counter.
// - select a high and select b low divides by 64, the normal mode.
// - both selects low divides by 65, prescaler at 5 on the last count only.
// - select b high divides by 72, prescaler by 4 and counter by 18.
// - the counter advances synchronously off the prescaler's terminal count.
// - counting advances only on rising edges of the input.
// - the output falls at the final count, one delay after the input edge.
// - the output rises at input count 32, one delay after the input edge.
// - the state holds indefinitely when no input edges arrive.
`timescale 1ns/1ps
module tmp_prescaler (
  input  wire logic ref_clk,          // design clock, 125 MHz
  input  wire logic rst,              // synchronous reset, active high
  input  wire logic hf_in,            // signal to be divided
  input  wire logic modulus_select_a, // modulus control a
  input  wire logic modulus_select_b, // modulus control b
  output logic      div_out           // divided output
);

  tmp_pkg::tmp_state_type st_r;
  tmp_pkg::tmp_state_type st_nxt;

  logic       in_edge;
  logic       cnt_last_hit;
  logic       pre_wrap;
  logic [2:0] pre_top;

  localparam tmp_pkg::tmp_state_type ST_RESET = '{
    in_prev: 1'b0,
    pre:     tmp_pkg::PRE_FIRST,
    cnt:     tmp_pkg::CNT_FIRST,
    out:     1'b0,
    mode:    tmp_pkg::MODE_DIV64
  };

  always_comb begin
    st_nxt       = st_r;
    st_nxt.in_prev = hf_in;
    in_edge      = hf_in & ~st_r.in_prev;
    cnt_last_hit = (st_r.cnt == tmp_pkg::cnt_last(st_r.mode));
    // extra input period only in the counter's last count
    pre_top      = (st_r.mode == tmp_pkg::MODE_DIV65 && cnt_last_hit) ?
                   tmp_pkg::PRE_TOP_DIV5 : tmp_pkg::PRE_TOP_DIV4;
    pre_wrap     = (st_r.pre == pre_top);
    if (in_edge) begin
      if (pre_wrap) begin
        st_nxt.pre = tmp_pkg::PRE_FIRST;
        if (cnt_last_hit) begin
          st_nxt.cnt  = tmp_pkg::CNT_FIRST;
          // new selects only take hold at a cycle boundary
          st_nxt.mode = tmp_pkg::mode_of(modulus_select_a,
                                         modulus_select_b);
        end else begin
          st_nxt.cnt = st_r.cnt + 5'h01;
        end
      end else begin
        st_nxt.pre = st_r.pre + 3'h1;
      end
    end
    if (in_edge && pre_wrap && cnt_last_hit) begin
      st_nxt.out = 1'b0;
    end else if (in_edge && pre_wrap &&
                 st_r.cnt == tmp_pkg::CNT_RISE - 5'h01) begin
      st_nxt.out = 1'b1;
    end
  end

  // no edge, no change: nothing here decays or times out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign div_out = st_r.out;

  // checking helper: input edges since the last cycle boundary
  // kept apart from the state record so it can never steer the divider
  localparam int         EDGE_DLY = tmp_pkg::OUTPUT_EDGE_DELAY_CYC;
  // count 32 is counter 8 with the prescaler back at zero, four per step
  localparam logic [6:0] RISE_POS = {tmp_pkg::CNT_RISE, 2'h0};

  logic [6:0] pos_r;
  logic       wrap_now;
  logic       rise_now;
  logic       seen_wrap_r;

  assign wrap_now = in_edge && pre_wrap && cnt_last_hit;
  assign rise_now = in_edge && pre_wrap &&
                    st_r.cnt == tmp_pkg::CNT_RISE - 5'h01;

  // the cycle after reset starts from no boundary, so lengths are
  // only judged once a first boundary has passed
  // pos_r wraps at 128, well above the longest cycle of 72 inputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_r       <= 7'h00;
      seen_wrap_r <= 1'h0;
    end else if (wrap_now) begin
      pos_r       <= 7'h00;
      seen_wrap_r <= 1'h1;
    end else if (in_edge) begin
      pos_r <= pos_r + 7'h01;
    end
  end

  // all checks run on the design clock and rest while reset is held
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // cycle length, from one boundary edge to the next
  div64_len_a: assert property (
    wrap_now && seen_wrap_r && st_r.mode == tmp_pkg::MODE_DIV64
    |-> pos_r == tmp_pkg::LAST_POS_64)
    else $error("divide by 64 cycle wrong length");

  div65_len_a: assert property (
    wrap_now && seen_wrap_r && st_r.mode == tmp_pkg::MODE_DIV65
    |-> pos_r == tmp_pkg::LAST_POS_65)
    else $error("divide by 65 cycle wrong length");

  div72_len_a: assert property (
    wrap_now && seen_wrap_r && st_r.mode == tmp_pkg::MODE_DIV72
    |-> pos_r == tmp_pkg::LAST_POS_72)
    else $error("divide by 72 cycle wrong length");

  // prescaler and counter ranges
  pre_range_a: assert property (
    st_r.pre == tmp_pkg::PRE_TOP_DIV5
    |-> st_r.mode == tmp_pkg::MODE_DIV65 && st_r.cnt == tmp_pkg::CNT_LAST_16)
    else $error("prescaler at five outside last count");

  pre_bound_a: assert property (
    st_r.pre <= tmp_pkg::PRE_TOP_DIV5)
    else $error("prescaler count out of range");

  cnt_bound_a: assert property (
    st_r.cnt <= tmp_pkg::cnt_last(st_r.mode))
    else $error("counter beyond last count of its modulus");

  // counting only on input edges, and only through the prescaler
  cnt_step_a: assert property (
    $changed(st_r.cnt)
    |-> st_r.pre == tmp_pkg::PRE_FIRST && $past(pre_wrap) && $past(in_edge))
    else $error("counter moved without prescaler wrap");

  hold_idle_a: assert property (
    !in_edge
    |=> $stable(st_r.cnt) && $stable(st_r.pre) && $stable(div_out))
    else $error("state moved without input edge");

  // eight idle clocks stand for any idle stretch; the rule has no bound
  static_hold_a: assert property (
    !in_edge [*8] |=> $stable(st_r.cnt))
    else $error("state lost while input idle");

  // output edges: where in the cycle, and how long after the input edge
  out_fall_a: assert property (
    $fell(div_out)
    |-> st_r.cnt == tmp_pkg::CNT_FIRST && st_r.pre == tmp_pkg::PRE_FIRST
        && $past(in_edge))
    else $error("output fell away from final count");

  // the delay is one design clock: the flip-flop that holds the output
  fall_delay_a: assert property (
    wrap_now |-> ##EDGE_DLY !div_out)
    else $error("output did not fall after final count");

  out_rise_a: assert property (
    $rose(div_out)
    |-> st_r.cnt == tmp_pkg::CNT_RISE && st_r.pre == tmp_pkg::PRE_FIRST
        && pos_r == RISE_POS)
    else $error("output rose away from count 32");

  rise_delay_a: assert property (
    rise_now |-> ##EDGE_DLY div_out)
    else $error("output did not rise at count 32");

  // the output follows the counter alone: low below 8, high from 8 on
  out_level_a: assert property (
    div_out == (st_r.cnt >= tmp_pkg::CNT_RISE))
    else $error("output level disagrees with count");

  // modulus selects: taken at the boundary only
  mode_hold_a: assert property (
    !wrap_now |=> $stable(st_r.mode))
    else $error("modulus changed inside a cycle");

  take_64_a: assert property (
    wrap_now && modulus_select_a && !modulus_select_b
    |=> st_r.mode == tmp_pkg::MODE_DIV64)
    else $error("selects a high b low not taken as 64");

  take_65_a: assert property (
    wrap_now && !modulus_select_a && !modulus_select_b
    |=> st_r.mode == tmp_pkg::MODE_DIV65)
    else $error("selects both low not taken as 65");

  // b high wins over a, so both settings of a give 72
  take_72_a: assert property (
    wrap_now && modulus_select_b
    |=> st_r.mode == tmp_pkg::MODE_DIV72)
    else $error("select b high not taken as 72");

  // main scenarios; the last is an idle gap ended by a fresh input edge
  cov_div64_c: cover property (
    wrap_now && seen_wrap_r && st_r.mode == tmp_pkg::MODE_DIV64);
  cov_div65_c: cover property (
    wrap_now && seen_wrap_r && st_r.mode == tmp_pkg::MODE_DIV65);
  cov_div72_c: cover property (
    wrap_now && seen_wrap_r && st_r.mode == tmp_pkg::MODE_DIV72);
  cov_rise_c:  cover property ($rose(div_out));
  cov_idle_c:  cover property (!in_edge [*8] ##1 in_edge);

endmodule

// File: verification/tmp_synth_model.sv
// synthesizer side model: sets the modulus selects for the prescaler
// assumes the bench asks for a mode through want_a and want_b
`timescale 1ns/1ps
module tmp_synth_model (
  input  wire logic ref_clk,          // design clock
  input  wire logic div_out,          // divided output from the block
  input  wire logic want_a,           // requested select a
  input  wire logic want_b,           // requested select b
  output logic      modulus_select_a, // modulus control a
  output logic      modulus_select_b  // modulus control b
);
  logic prev_r;
  initial begin
    modulus_select_a = 1'b1;
    modulus_select_b = 1'b0;
    prev_r = 1'b0;
  end
  // change at the output rise: mid-cycle, clear of the boundary
  always @(negedge ref_clk) begin
    if (div_out && !prev_r) begin
      modulus_select_a <= want_a;
      modulus_select_b <= want_b;
    end
    prev_r <= div_out;
  end
endmodule

// File: verification/tmp_prescaler_tb_top.sv
// testbench for the triple-modulus prescaler
// assumes the synthesizer model drives the selects
`timescale 1ns/1ps
module tmp_prescaler_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hf_in = 1'b0;
  logic want_a = 1'b1;
  logic want_b = 1'b0;
  logic sel_a;
  logic sel_b;
  logic div_out;
  int   num_errors = 0;
  int   comparisons = 0;
  always #4 ref_clk = ~ref_clk;
  tmp_prescaler tmp_prescaler_inst (.ref_clk(ref_clk), .rst(rst),
    .hf_in(hf_in), .modulus_select_a(sel_a), .modulus_select_b(sel_b),
    .div_out(div_out));
  tmp_synth_model tmp_synth_model_inst (.ref_clk(ref_clk),
    .div_out(div_out), .want_a(want_a), .want_b(want_b),
    .modulus_select_a(sel_a), .modulus_select_b(sel_b));
  task automatic check(input string what, input logic [6:0] exp,
                       input logic [6:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one input edge; output settles a clock after the edge is seen
  task automatic pulse(input int hold);
    @(negedge ref_clk);
    hf_in = 1'b1;
    repeat (hold) @(negedge ref_clk);
    hf_in = 1'b0;
    @(negedge ref_clk);
  endtask
  // input edges until div_out reaches lvl; idles the input at hold_at
  task automatic edges_to(input logic lvl, input int hold_at,
                          output logic [6:0] n);
    n = 7'h7f;
    for (int i = 1; i < 100; i++) begin
      pulse(i == hold_at ? 50 : 1);
      if (i == hold_at) repeat (200) @(negedge ref_clk);
      if (div_out === lvl) begin
        n = i[6:0];
        break;
      end
    end
    if (n === 7'h7f) begin
      check("output edge found", 7'h00, n);
      finish_test();
    end
  endtask
  // first cycle latches the new mode, second is measured
  task automatic run_mode(input string name, input logic a, input logic b,
                          input logic [6:0] modulus, input int hold_at);
    logic [6:0] n;
    want_a = a;
    want_b = b;
    edges_to(1'b1, 0, n);
    edges_to(1'b0, 0, n);
    edges_to(1'b1, hold_at, n);
    check({name, " rise"}, 7'h20, n);
    edges_to(1'b0, 0, n);
    check({name, " fall"}, modulus - 7'h20, n);
    $display("test %s done", name);
  endtask
  initial begin
    logic [6:0] n;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    edges_to(1'b1, 0, n);
    check("first rise", 7'h20, n);
    edges_to(1'b0, 0, n);
    check("first fall", 7'h20, n);
    $display("test reset cycle done");
    run_mode("div65", 1'b0, 1'b0, 7'h41, 0);
    run_mode("div72 a low", 1'b0, 1'b1, 7'h48, 0);
    run_mode("div72 a high", 1'b1, 1'b1, 7'h48, 10);
    run_mode("div64", 1'b1, 1'b0, 7'h40, 31);
    finish_test();
  end
endmodule
